/* File: logic/ascp_regs.svh */
// Register offsets, field positions, reset values and frame sizes of the serial port
`ifndef ASCP_REGS_SVH
`define ASCP_REGS_SVH

`define ASCP_FRAME_BITS   30
`define ASCP_ADDR_BITS    10
`define ASCP_DATA_BITS    20
`define ASCP_MEM_DEPTH    1024
`define ASCP_CNT_BITS     5
`define ASCP_LAST_ADDR_IX 5'h09
`define ASCP_LAST_BIT_IX  5'h1d

`define ASCP_CTL_OFFSET   10'h000
`define ASCP_CTL_RESET    20'h00000

`define ASCP_RD_SEL_POS   0
`define ASCP_TURN_EN_POS  1
`define ASCP_SDO_SEL_POS  2

`endif

/* File: logic/ascp_pkg.sv */
// Types shared by the serial configuration port
`include "ascp_regs.svh"

package ascp_pkg;

  typedef struct packed {
    logic [`ASCP_ADDR_BITS-1:0] addr;
    logic [`ASCP_DATA_BITS-1:0] data;
  } ascp_frame_s;

  typedef struct packed {
    logic sdo_sel;
    logic turn_en;
    logic rd_sel;
  } ascp_ctl_s;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ADDR,
    PH_PASS,
    PH_WAIT,
    PH_DRIVE
  } ascp_phase_e;

endpackage

/* File: logic/ascp_mem.sv */
// Register storage of the serial port, one write port and one registered read port
`timescale 1ns/1ps
`include "ascp_regs.svh"

module ascp_mem (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  // Write port
  input  wire logic                       wr_en,
  input  wire logic [`ASCP_ADDR_BITS-1:0] wr_addr,
  input  wire logic [`ASCP_DATA_BITS-1:0] wr_data,
  // Read port
  input  wire logic                       rd_en,
  input  wire logic [`ASCP_ADDR_BITS-1:0] rd_addr,
  output logic      [`ASCP_DATA_BITS-1:0] rd_data_ff
);

  // No reset on the array, so it maps onto plain RAM
  logic [`ASCP_DATA_BITS-1:0] mem_q [`ASCP_MEM_DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= '0;
    end else if (rd_en) begin
      rd_data_ff <= mem_q[rd_addr];
    end
  end

endmodule

/* File: logic/ascp_top.sv */
// Serial configuration port: frame capture, register write and readback
//
// Summary of operation
// RQ1: Frame is 10 address then 20 data bits.
// RQ2: Host sends address MSB first.
// RQ3: Shift SDI on SCLK rise while select low.
// RQ4: Select rising edge latches whole frame.
// RQ5: Control bit 0 of address 0 picks read.
// RQ6: Write mode stores data at frame address.
// RQ7: Trailing partial frame is discarded.
// RQ8: Readback pin driven only when function selected.
// RQ9: Turnaround off: SDI input, data on SDO.
// RQ10: Turnaround on: SDI becomes bidirectional.
// RQ11: SDI turns on falling edge after address.
// RQ12: SDI pull-down always enabled.
// RQ13: Host releases SDI by that falling edge.
// RQ14: Read data leaves MSB first, once per cycle.
`timescale 1ns/1ps
`include "ascp_regs.svh"

module ascp_top (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  // Serial pins from the host
  input  wire logic                       sclk,
  input  wire logic                       frame_select_low_n,
  input  wire logic                       sdi_in,
  output logic                            sdi_out,
  output logic                            sdi_oe,
  output logic                            sdi_pulldown_en,
  // Shared readback / general-purpose pin
  input  wire logic                       gpio_out,
  input  wire logic                       gpio_oe,
  output logic                            sdo_out_ff,
  output logic                            sdo_oe_ff,
  // Control state seen by the rest of the device
  output ascp_pkg::ascp_ctl_s             ctl_ff,
  output logic                            wr_pulse_ff,
  output ascp_pkg::ascp_frame_s           latch_ff
);

  localparam int PIN_N = 3;
  localparam int IX_SCLK = 0;
  localparam int IX_SEL = 1;
  localparam int IX_SDI = 2;

  function automatic logic is_ctl(input logic [`ASCP_ADDR_BITS-1:0] a);
    is_ctl = (a == `ASCP_CTL_OFFSET);
  endfunction

  // Pin synchronisers: three stages, a change counts once stages two and three agree
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] s1_ff;
  logic [PIN_N-1:0] s2_ff;
  logic [PIN_N-1:0] s3_ff;
  logic [PIN_N-1:0] flt_ff;
  logic [PIN_N-1:0] rise;
  logic [PIN_N-1:0] fall;

  assign pin_raw = {sdi_in, frame_select_low_n, sclk};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          // Each stage resets to its pin's idle level, so reset makes no false edge
          s1_ff[gi]  <= (gi == IX_SEL);
          s2_ff[gi]  <= (gi == IX_SEL);
          s3_ff[gi]  <= (gi == IX_SEL);
          flt_ff[gi] <= (gi == IX_SEL);
        end else begin
          s1_ff[gi] <= pin_raw[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          if (s2_ff[gi] == s3_ff[gi]) begin
            flt_ff[gi] <= s3_ff[gi];
          end
        end
      end
      assign rise[gi] = (s2_ff[gi] == s3_ff[gi]) && s3_ff[gi] && !flt_ff[gi];
      assign fall[gi] = (s2_ff[gi] == s3_ff[gi]) && !s3_ff[gi] && flt_ff[gi];
    end
  endgenerate

  logic sel_low;
  logic shift_en;
  logic sen_rise;
  logic sdi_bit;

  assign sel_low  = !flt_ff[IX_SEL];
  assign shift_en = rise[IX_SCLK] && sel_low;
  assign sen_rise = rise[IX_SEL];
  assign sdi_bit  = s3_ff[IX_SDI];

  // Input shift register and bit counter
  logic [`ASCP_FRAME_BITS-2:0] shift_ff;
  logic [`ASCP_CNT_BITS-1:0]   cnt_ff;
  logic [`ASCP_FRAME_BITS-1:0] shift_next;
  logic                        last_bit;
  logic                        addr_done;

  assign shift_next = {shift_ff, sdi_bit};
  assign last_bit   = shift_en && (cnt_ff == `ASCP_LAST_BIT_IX);
  assign addr_done  = shift_en && (cnt_ff == `ASCP_LAST_ADDR_IX);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_ff <= '0;
    end else if (shift_en) begin
      shift_ff <= shift_next[`ASCP_FRAME_BITS-2:0]; // RQ3
    end
  end

  // Counter wraps every frame so back-to-back frames within one select are kept apart
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (sen_rise) begin
      cnt_ff <= '0;
    end else if (last_bit) begin
      cnt_ff <= '0; // RQ1
    end else if (shift_en) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // Last complete word of the stream; bits after it never reach the latch
  ascp_pkg::ascp_frame_s pend_ff;
  logic                  pend_vld_ff;
  logic                  take_word;
  ascp_pkg::ascp_frame_s take_data;

  // A word whose last bit lands as the select rises still counts as complete
  assign take_word = pend_vld_ff || last_bit;
  assign take_data = last_bit ? ascp_pkg::ascp_frame_s'(shift_next) : pend_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff     <= '0;
      pend_vld_ff <= 1'b0;
    end else if (sen_rise) begin
      pend_vld_ff <= 1'b0;
    end else if (last_bit) begin
      pend_ff     <= shift_next; // RQ1
      pend_vld_ff <= 1'b1;
    end
  end

  // Parallel latch, loaded in one step on the select rising edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_ff    <= '0;
      wr_pulse_ff <= 1'b0;
    end else begin
      wr_pulse_ff <= sen_rise && take_word; // RQ7
      if (sen_rise && take_word) begin
        latch_ff <= take_data; // RQ4
      end
    end
  end

  // Address 0 may always be written, so software can leave read mode again
  logic wr_ok;
  logic mem_we;

  assign wr_ok  = wr_pulse_ff && (!ctl_ff.rd_sel || is_ctl(latch_ff.addr)); // RQ5
  assign mem_we = wr_ok && !is_ctl(latch_ff.addr); // RQ6

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_ff <= ascp_pkg::ascp_ctl_s'(3'(`ASCP_CTL_RESET));
    end else if (wr_ok && is_ctl(latch_ff.addr)) begin
      ctl_ff.rd_sel  <= latch_ff.data[`ASCP_RD_SEL_POS]; // RQ5
      ctl_ff.turn_en <= latch_ff.data[`ASCP_TURN_EN_POS];
      ctl_ff.sdo_sel <= latch_ff.data[`ASCP_SDO_SEL_POS];
    end
  end

  logic [`ASCP_DATA_BITS-1:0] rd_data;
  logic                       rd_ctl_ff;

  ascp_mem u_mem (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .wr_en      (mem_we),
    .wr_addr    (latch_ff.addr),
    .wr_data    (latch_ff.data),
    .rd_en      (addr_done),
    .rd_addr    (shift_next[`ASCP_ADDR_BITS-1:0]),
    .rd_data_ff (rd_data)
  );

  // Frame phase; readback only starts once the full address is in
  ascp_pkg::ascp_phase_e phase_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= ascp_pkg::PH_IDLE;
    end else if (!sel_low) begin
      phase_ff <= ascp_pkg::PH_IDLE;
    end else begin
      case (phase_ff)
        ascp_pkg::PH_IDLE: begin
          phase_ff <= ascp_pkg::PH_ADDR;
        end
        ascp_pkg::PH_ADDR: begin
          if (addr_done) begin
            phase_ff <= ctl_ff.rd_sel ? ascp_pkg::PH_WAIT : ascp_pkg::PH_PASS;
          end
        end
        ascp_pkg::PH_WAIT: begin
          if (fall[IX_SCLK]) begin
            phase_ff <= ascp_pkg::PH_DRIVE; // RQ11
          end
        end
        ascp_pkg::PH_PASS: begin
          phase_ff <= ascp_pkg::PH_PASS;
        end
        ascp_pkg::PH_DRIVE: begin
          phase_ff <= ascp_pkg::PH_DRIVE;
        end
        default: begin
          phase_ff <= ascp_pkg::PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ctl_ff <= 1'b0;
    end else if (addr_done) begin
      rd_ctl_ff <= is_ctl(shift_next[`ASCP_ADDR_BITS-1:0]);
    end
  end

  // Readback shifter: MSB first, one bit per falling edge of SCLK
  logic [`ASCP_DATA_BITS-1:0] out_ff;
  logic                       drive_ff;
  logic [`ASCP_DATA_BITS-1:0] ctl_word;

  assign ctl_word = {{(`ASCP_DATA_BITS-3){1'b0}}, ctl_ff.sdo_sel, ctl_ff.turn_en, ctl_ff.rd_sel};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_ff   <= '0;
      drive_ff <= 1'b0;
    end else if (!sel_low) begin
      drive_ff <= 1'b0;
    end else if (phase_ff == ascp_pkg::PH_WAIT && fall[IX_SCLK]) begin
      out_ff   <= rd_ctl_ff ? ctl_word : rd_data; // RQ14
      drive_ff <= 1'b1; // RQ11
    end else if (phase_ff == ascp_pkg::PH_DRIVE && fall[IX_SCLK]) begin
      out_ff <= {out_ff[`ASCP_DATA_BITS-2:0], 1'b0}; // RQ14
    end
  end

  // Three-wire readback turns SDI round; the host has let go by then
  assign sdi_out         = out_ff[`ASCP_DATA_BITS-1];
  assign sdi_oe          = drive_ff && ctl_ff.turn_en; // RQ10 RQ13
  assign sdi_pulldown_en = 1'b1; // RQ12

  // Shared pin stays with the general-purpose logic until readback is selected
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_out_ff <= 1'b0;
      sdo_oe_ff  <= 1'b0;
    end else if (ctl_ff.sdo_sel) begin
      sdo_out_ff <= out_ff[`ASCP_DATA_BITS-1]; // RQ8
      sdo_oe_ff  <= drive_ff && !ctl_ff.turn_en; // RQ9
    end else begin
      sdo_out_ff <= gpio_out;
      sdo_oe_ff  <= gpio_oe; // RQ8
    end
  end

  property p_shift_gated;
    @(posedge sys_clk) disable iff (!rst_n)
      rise[IX_SCLK] && !sel_low |=> $stable(shift_ff);
  endproperty
  a_shift_gated: assert property (p_shift_gated) // RQ3
    else $error("shift register moved while frame select high");

  property p_word_after_30;
    @(posedge sys_clk) disable iff (!rst_n)
      last_bit && !sen_rise |=> pend_vld_ff && pend_ff == $past(shift_next);
  endproperty
  a_word_after_30: assert property (p_word_after_30) // RQ1
    else $error("complete word not captured after thirtieth bit");

  property p_latch_on_rise;
    @(posedge sys_clk) disable iff (!rst_n)
      sen_rise && take_word |=> wr_pulse_ff && latch_ff == $past(take_data);
  endproperty
  a_latch_on_rise: assert property (p_latch_on_rise) // RQ4
    else $error("latch not loaded on select rising edge");

  property p_partial_dropped;
    @(posedge sys_clk) disable iff (!rst_n)
      sen_rise && !take_word |=> !wr_pulse_ff ##1 $stable(ctl_ff);
  endproperty
  a_partial_dropped: assert property (p_partial_dropped) // RQ7
    else $error("partial frame caused a register update");

  property p_write_mode;
    @(posedge sys_clk) disable iff (!rst_n)
      wr_pulse_ff && !ctl_ff.rd_sel && !is_ctl(latch_ff.addr) |-> mem_we;
  endproperty
  a_write_mode: assert property (p_write_mode) // RQ6
    else $error("write frame not stored");

  property p_read_no_write;
    @(posedge sys_clk) disable iff (!rst_n)
      ctl_ff.rd_sel && !is_ctl(latch_ff.addr) |-> !mem_we;
  endproperty
  a_read_no_write: assert property (p_read_no_write) // RQ5
    else $error("register written while in read mode");

  property p_sdo_gpio;
    @(posedge sys_clk) disable iff (!rst_n)
      !ctl_ff.sdo_sel |=> sdo_oe_ff == $past(gpio_oe) && sdo_out_ff == $past(gpio_out);
  endproperty
  a_sdo_gpio: assert property (p_sdo_gpio) // RQ8
    else $error("readback drove the shared pin while not selected");

  property p_four_wire;
    @(posedge sys_clk) disable iff (!rst_n)
      !ctl_ff.turn_en |-> !sdi_oe;
  endproperty
  a_four_wire: assert property (p_four_wire) // RQ9
    else $error("SDI driven in four-wire mode");

  property p_turn_edge;
    @(posedge sys_clk) disable iff (!rst_n)
      phase_ff == ascp_pkg::PH_WAIT && fall[IX_SCLK] && sel_low && ctl_ff.turn_en
      |=> sdi_oe && sdi_out == ($past(rd_ctl_ff) ? $past(ctl_word[`ASCP_DATA_BITS-1])
                                                 : $past(rd_data[`ASCP_DATA_BITS-1]));
  endproperty
  a_turn_edge: assert property (p_turn_edge) // RQ11
    else $error("SDI not turned round on falling edge after address");

  property p_msb_shift;
    @(posedge sys_clk) disable iff (!rst_n)
      phase_ff == ascp_pkg::PH_DRIVE && fall[IX_SCLK] && sel_low
      |=> out_ff == {$past(out_ff[`ASCP_DATA_BITS-2:0]), 1'b0};
  endproperty
  a_msb_shift: assert property (p_msb_shift) // RQ14
    else $error("readback not shifted MSB first");

  property p_pulldown;
    @(posedge sys_clk) disable iff (!rst_n)
      1'b1 |-> sdi_pulldown_en;
  endproperty
  a_pulldown: assert property (p_pulldown) // RQ12
    else $error("SDI pull-down released");

endmodule

/* File: test/ascp_host.sv */
// Behavioural serial host that frames words onto the configuration port
`timescale 1ns/1ps

module ascp_host (
  // Clock
  input  wire logic sys_clk,
  // Serial pins
  output logic      sclk,
  output logic      frame_select_low_n,
  output logic      sdi_w,
  input  wire logic sdi_out,
  input  wire logic sdi_oe,
  input  wire logic sdi_pulldown_en,
  // Shared readback pin
  input  wire logic sdo_out_ff,
  input  wire logic sdo_oe_ff
);
  logic h_oe;
  logic h_d;

  initial begin
    sclk = 1'b0;
    frame_select_low_n = 1'b1;
    h_oe = 1'b0;
    h_d = 1'b0;
  end

  // Two drivers at once read as unknown so a clash can never pass a compare
  assign sdi_w = (h_oe & sdi_oe) ? 1'bx : h_oe ? h_d : sdi_oe ? sdi_out :
                 sdi_pulldown_en ? 1'b0 : ~h_d;

  // Low phase is long so readback has settled before the host samples it
  task automatic xfer(input logic [59:0] bits, input int n, input logic three,
                      output logic [19:0] rb);
    rb = 20'h0;
    @(posedge sys_clk);
    frame_select_low_n <= 1'b0;
    h_oe <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b0;
      if (three && i == 10) h_oe <= 1'b0;
      h_d <= bits[n-1-i];
      repeat (8) @(posedge sys_clk);
      if (i >= 10 && i < 30) begin
        rb = {rb[18:0], three ? sdi_w : (sdo_oe_ff ? sdo_out_ff : ~sdo_out_ff)};
      end
      sclk <= 1'b1;
      repeat (4) @(posedge sys_clk);
    end
    sclk <= 1'b0;
    repeat (4) @(posedge sys_clk);
    frame_select_low_n <= 1'b1;
    h_oe <= 1'b0;
  endtask

  // Stray clocks while deselected must leave the shift register alone
  task automatic idle_clocks(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      sclk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      sclk <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
  endtask
endmodule

/* File: test/tb.sv */
// Self-checking bench of the serial configuration port
`timescale 1ns/1ps

module tb;
  logic                  sys_clk;
  logic                  rst_n;
  logic                  sclk;
  logic                  sel_n;
  logic                  sdi_w;
  logic                  sdi_out;
  logic                  sdi_oe;
  logic                  sdi_pulldown_en;
  logic                  gpio_out;
  logic                  gpio_oe;
  logic                  gpio_q;
  logic                  gpio_oe_q;
  logic                  sdo_out_ff;
  logic                  sdo_oe_ff;
  ascp_pkg::ascp_ctl_s   ctl_ff;
  logic                  wr_pulse_ff;
  ascp_pkg::ascp_frame_s latch_ff;
  logic [19:0]           mem [int];
  logic [9:0]            wa [$];
  logic [2:0]            m_ctl;
  logic [29:0]           m_latch;
  logic                  mon_on;
  int                    n_fail;
  int                    checked;
  int                    pulses;

  ascp_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk), .frame_select_low_n(sel_n),
    .sdi_in(sdi_w), .sdi_out(sdi_out), .sdi_oe(sdi_oe), .sdi_pulldown_en(sdi_pulldown_en),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .sdo_out_ff(sdo_out_ff), .sdo_oe_ff(sdo_oe_ff),
    .ctl_ff(ctl_ff), .wr_pulse_ff(wr_pulse_ff), .latch_ff(latch_ff));

  ascp_host host (.sys_clk(sys_clk), .sclk(sclk), .frame_select_low_n(sel_n), .sdi_w(sdi_w),
    .sdi_out(sdi_out), .sdi_oe(sdi_oe), .sdi_pulldown_en(sdi_pulldown_en),
    .sdo_out_ff(sdo_out_ff), .sdo_oe_ff(sdo_oe_ff));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [29:0] exp, input logic [29:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Monitors pause while control bits change at a frame end
  task automatic settle();
    mon_on = 1'b0;
    pulses = 0;
    repeat (10) begin
      @(posedge sys_clk);
      if (wr_pulse_ff === 1'b1) pulses++;
    end
    mon_on = 1'b1;
  endtask

  task automatic wr(input logic [9:0] a, input logic [19:0] d);
    logic [19:0] rb;
    host.xfer({30'h0, a, d}, 30, 1'b0, rb);
    // Model moves before the monitors wake again
    m_latch = {a, d};
    if (a == 10'h0) m_ctl = d[2:0];
    else if (!m_ctl[0]) mem[a] = d;
    settle();
    chk("pulses", 30'h1, 30'(pulses));
    chk("latch", {a, d}, latch_ff);
    chk("ctl", {27'h0, m_ctl}, {27'h0, ctl_ff});
  endtask

  task automatic rd(input logic [9:0] a, input logic [19:0] d);
    logic [19:0] rb;
    logic [19:0] exp;
    logic        three;
    logic        show;
    three = m_ctl[1];
    show = m_ctl[1] | m_ctl[2];
    exp = (a == 10'h0) ? {17'h0, m_ctl} : mem[a];
    host.xfer({30'h0, a, d}, 30, three, rb);
    if (!three && a == 10'h0) m_ctl = d[2:0];
    settle();
    if (show) chk("readback", {10'h0, exp}, {10'h0, rb});
    if (!three) chk("ctl", {27'h0, m_ctl}, {27'h0, ctl_ff});
  endtask

  always @(posedge sys_clk) begin
    gpio_out <= 1'($urandom);
    gpio_oe <= 1'($urandom);
    gpio_q <= gpio_out;
    gpio_oe_q <= gpio_oe;
    if (mon_on && !m_ctl[2]) chk("sdo_gpio", {29'h0, gpio_q}, {29'h0, sdo_out_ff});
    if (mon_on && !m_ctl[2]) chk("sdo_oe_gpio", {29'h0, gpio_oe_q}, {29'h0, sdo_oe_ff});
    if (mon_on && !m_ctl[1]) chk("sdi_oe", 30'h0, {29'h0, sdi_oe});
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    give_verdict();
  end

  initial begin
    logic [9:0]  a;
    logic [19:0] rb;
    logic [29:0] w;
    logic [2:0]  modes [3];
    modes = '{3'h1, 3'h5, 3'h3};
    void'($urandom(32'hf8b43888));
    n_fail = 0;
    checked = 0;
    mon_on = 1'b0;
    m_ctl = 3'h0;
    rst_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("rst_ctl", 30'h0, {27'h0, ctl_ff});
    chk("rst_latch", 30'h0, latch_ff);
    chk("rst_oe", 30'h0, {27'h0, sdi_oe, sdo_oe_ff, wr_pulse_ff});
    chk("pulldown", 30'h1, {29'h0, sdi_pulldown_en});
    rst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    mon_on = 1'b1;
    for (int k = 0; k < 6; k++) begin
      a = (k == 0) ? 10'h3ff : (k == 1) ? 10'h001 : 10'($urandom_range(1022, 2));
      wa.push_back(a);
      wr(a, 20'($urandom));
    end
    // A short frame leaves latch and registers alone
    w = {10'h2aa, 20'($urandom)};
    host.xfer({30'h0, w}, 29, 1'b0, rb);
    settle();
    chk("pulses", 30'h0, 30'(pulses));
    chk("latch", m_latch, latch_ff);
    // Clocks with the select high shift nothing and latch nothing
    host.idle_clocks(3);
    settle();
    chk("pulses", 30'h0, 30'(pulses));
    chk("latch", m_latch, latch_ff);
    w = {10'h155, 20'($urandom)};
    host.xfer({15'h0, w, 15'h7fff}, 45, 1'b0, rb);
    settle();
    chk("pulses", 30'h1, 30'(pulses));
    chk("latch", w, latch_ff);
    mem[10'h155] = w[19:0];
    wa.push_back(10'h155);
    // Four-wire without pin, four-wire on pin, then three-wire to the end
    foreach (modes[j]) begin
      wr(10'h0, {17'h0, modes[j]});
      foreach (wa[i]) rd(wa[i], 20'($urandom));
      rd(10'h0, 20'h0);
    end
    give_verdict();
  end
endmodule
